/* File: bench/ebac_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// processor core stand-in: io cycles that hold on the stall line
// ****************************************************************
module ebac_cpu (
    input  wire logic       clk,
    input  wire logic       cpuStall,
    input  wire logic [7:0] ioRdata,
    output logic            ioWrite,
    output logic            ioRead,
    output logic      [5:0] ioAddr,
    output logic      [7:0] ioWdata
);
    // idle bus at time zero; no interrupts taken, so no nesting
    initial begin
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioAddr = 6'h00;
        ioWdata = 8'h00;
    end
    // next instruction waits while the core is halted
    task automatic hold;
        #1;
        for (int i = 0; i < 8 && cpuStall; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    // one io write; address and data lines driven to their complements afterwards
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        ioWrite <= 1'b1;
        ioAddr <= a;
        ioWdata <= d;
        @(posedge clk);
        ioWrite <= 1'b0;
        ioAddr <= ~a;
        ioWdata <= ~d;
        hold();
    endtask
    // one io read
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        ioRead <= 1'b1;
        ioAddr <= a;
        @(posedge clk);
        ioRead <= 1'b0;
        ioAddr <= ~a;
        hold();
        @(posedge clk);
        #1;
        d = ioRdata;
    endtask
endmodule
`default_nettype wire

/* File: bench/ebac_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port level checker for the byte access controller
// ****************************************************************
module ebac_top_chk #(
    parameter int WRITE_OSC_CYCLES = 4096
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       ioWrite,
    input wire logic       ioRead,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWdata,
    input wire logic       globalIntEnable,
    input wire logic       rcOsc,
    input wire logic [7:0] ioRdata,
    input wire logic       cpuStall,
    input wire logic       readyInterrupt
);
    logic       wrCtrl;
    logic       strobeOnly;
    logic       mweLive;
    logic [2:0] mweAge_reg;
    logic [2:0] mweAge_next;
    // control writes and the live window of master enable
    assign wrCtrl = ioWrite && (ioAddr == ebac_pkg::CTRL_OFFSET);
    assign strobeOnly = wrCtrl && ioWdata[1] && !ioWdata[0];
    assign mweLive = (mweAge_reg != 3'h0) && (mweAge_reg < 3'h4);
    // age since master enable was set, parks at zero after six
    always_comb begin
        mweAge_next = (mweAge_reg == 3'h0 || mweAge_reg == 3'h6) ? 3'h0 : mweAge_reg + 3'h1;
        if (wrCtrl && ioWdata[2] && !ioWdata[1]) begin
            mweAge_next = 3'h1;
        end
    end
    // age register
    always_ff @(posedge clk) begin
        mweAge_reg <= reset ? 3'h0 : mweAge_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    rd_stall_a: assert property (
        wrCtrl && ioWdata[0] && !ioWdata[1] && readyInterrupt |=> cpuStall[*4] ##1 !cpuStall)
        else $error("read stall length wrong");
    wr_stall_a: assert property (
        strobeOnly && mweLive && readyInterrupt |=> cpuStall[*2] ##1 !cpuStall)
        else $error("write stall length wrong");
    no_start_a: assert property (
        strobeOnly && mweAge_reg == 3'h0 && readyInterrupt |=> !cpuStall)
        else $error("write started without master enable");
    busy_int_a: assert property (
        strobeOnly && mweLive && readyInterrupt |-> ##[1:2] !readyInterrupt)
        else $error("ready interrupt kept during write");
    int_mask_a: assert property (!globalIntEnable |=> !readyInterrupt)
        else $error("ready interrupt without global enable");
    rie_off_a: assert property (wrCtrl && !ioWdata[3] |=> !readyInterrupt)
        else $error("ready interrupt with enable bit clear");
    mwe_expire_a: assert property (
        strobeOnly && mweAge_reg == 3'h5 && readyInterrupt |=> !cpuStall)
        else $error("write started after master enable timed out");
    rdata_hold_a: assert property (!ioRead |=> $stable(ioRdata))
        else $error("read data moved without a read");
    ctrl_zero_a: assert property (
        ioRead && ioAddr == ebac_pkg::CTRL_OFFSET |=> ioRdata[7:4] == 4'h0 && !ioRdata[0])
        else $error("control reserved or read strobe bit set");
    addr_top_a: assert property (
        ioRead && ioAddr == ebac_pkg::ADDR_OFFSET |=> ioRdata[7:6] == 2'h0)
        else $error("address top bits not zero");
    stall_cause_a: assert property ($rose(cpuStall) |-> $past(wrCtrl))
        else $error("stall without a strobe write");
    cover property (strobeOnly && mweLive);
    cover property (wrCtrl && ioWdata[0]);
    cover property ($fell(readyInterrupt));
endmodule
bind ebac_top ebac_top_chk #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) u_ebac_top_chk (
    .clk(clk), .reset(reset), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .globalIntEnable(globalIntEnable), .rcOsc(rcOsc),
    .ioRdata(ioRdata), .cpuStall(cpuStall), .readyInterrupt(readyInterrupt));
`default_nettype wire

/* File: bench/tb_ebac_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// testbench for the byte access controller
// ****************************************************************
module tb_ebac_top;
    localparam logic [5:0] ADDR = ebac_pkg::ADDR_OFFSET;
    localparam logic [5:0] DATA = ebac_pkg::DATA_OFFSET;
    localparam logic [5:0] CTRL = ebac_pkg::CTRL_OFFSET;
    logic       clk;
    logic       reset;
    logic       globalIntEnable;
    logic       rcOsc;
    logic       ioWrite;
    logic       ioRead;
    logic [5:0] ioAddr;
    logic [7:0] ioWdata;
    logic [7:0] ioRdata;
    logic       cpuStall;
    logic       readyInterrupt;
    int         mismatches = 0;
    int         nChecks = 0;
    // design with a short write time, and the core beside it
    ebac_top #(.WRITE_OSC_CYCLES(8)) u_ebac_top (.clk(clk), .reset(reset),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata),
        .globalIntEnable(globalIntEnable), .rcOsc(rcOsc), .ioRdata(ioRdata),
        .cpuStall(cpuStall), .readyInterrupt(readyInterrupt));
    ebac_cpu u_ebac_cpu (.clk(clk), .cpuStall(cpuStall), .ioRdata(ioRdata),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata));
    // comparison and short hands
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rdChk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_ebac_cpu.rd(a, d);
        chk(d, e);
    endtask
    task automatic readByte(input logic [5:0] a, input logic [7:0] e);
        u_ebac_cpu.wr(ADDR, {2'h0, a});
        u_ebac_cpu.wr(CTRL, 8'h09);
        rdChk(DATA, e);
    endtask
    // reset values, field widths, unmapped place, address kept over reset
    task automatic t_regs;
        rdChk(DATA, ebac_pkg::DATA_RESET);
        rdChk(CTRL, 8'h00);
        u_ebac_cpu.wr(ADDR, 8'hff);
        rdChk(ADDR, 8'h3f);
        rdChk(6'h1f, 8'h00);
        u_ebac_cpu.wr(ADDR, 8'h15);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdChk(ADDR, 8'h15);
    endtask
    // full write procedure, busy poll, then read back
    task automatic t_write(input logic [5:0] a, input logic [7:0] d);
        int         n;
        logic [7:0] c;
        u_ebac_cpu.wr(ADDR, {2'h0, a});
        u_ebac_cpu.wr(DATA, d);
        u_ebac_cpu.wr(CTRL, 8'h0c);
        u_ebac_cpu.wr(CTRL, 8'h0a);
        rdChk(CTRL, 8'h0a);
        chk({7'h0, readyInterrupt}, 8'h00);
        n = 0;
        c = 8'h0a;
        while (c[1] && n < 400) begin
            u_ebac_cpu.rd(CTRL, c);
            n++;
        end
        chk(c, 8'h08);
        chk(8'(n > 8 && n < 24), 8'h01);
        chk({7'h0, readyInterrupt}, 8'h01);
        u_ebac_cpu.wr(DATA, 8'h00);
        readByte(a, d);
    endtask
    // strobe refused without live master enable
    task automatic t_refuse;
        u_ebac_cpu.wr(DATA, 8'h11);
        u_ebac_cpu.wr(CTRL, 8'h0a);
        rdChk(CTRL, 8'h08);
        u_ebac_cpu.wr(CTRL, 8'h0e);
        u_ebac_cpu.wr(CTRL, 8'h0a);
        rdChk(CTRL, 8'h08);
        u_ebac_cpu.wr(CTRL, 8'h0c);
        // strobe lands one cycle after master enable has timed out
        repeat (3) @(posedge clk);
        u_ebac_cpu.wr(CTRL, 8'h0a);
        rdChk(CTRL, 8'h08);
        readByte(6'h00, 8'h5a);
    endtask
    // write aborted by a data write, then interrupt masking
    task automatic t_abort;
        u_ebac_cpu.wr(CTRL, 8'h0c);
        u_ebac_cpu.wr(CTRL, 8'h0a);
        u_ebac_cpu.wr(DATA, 8'h77);
        rdChk(CTRL, 8'h08);
        @(posedge clk);
        globalIntEnable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({7'h0, readyInterrupt}, 8'h00);
        globalIntEnable <= 1'b1;
        // enable bit off and on again with global enable set
        u_ebac_cpu.wr(CTRL, 8'h00);
        chk({7'h0, readyInterrupt}, 8'h00);
        u_ebac_cpu.wr(CTRL, 8'h08);
        chk({7'h0, readyInterrupt}, 8'h01);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // clock, free running oscillator, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rcOsc = 1'b0;
        forever #130 rcOsc = ~rcOsc;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        reset = 1'b1;
        globalIntEnable = 1'b0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        globalIntEnable <= 1'b1;
        t_regs();
        t_write(6'h3f, 8'ha5);
        t_write(6'h00, 8'h5a);
        readByte(6'h3f, 8'ha5);
        t_refuse();
        t_abort();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: pkg/ebac_pkg.sv */
// ****************************************************************
// constants for the byte access controller
// ****************************************************************
package ebac_pkg;
    // io addresses of the three access registers
    localparam logic [5:0] ADDR_OFFSET = 6'h1e;
    localparam logic [5:0] DATA_OFFSET = 6'h1d;
    localparam logic [5:0] CTRL_OFFSET = 6'h1c;
    // control register field positions
    localparam int READ_STROBE_BIT = 0;
    localparam int WRITE_STROBE_BIT = 1;
    localparam int MASTER_WRITE_ENABLE_BIT = 2;
    localparam int READY_INT_ENABLE_BIT = 3;
    // values after reset
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // counts
    localparam int MWE_TIMEOUT_CYCLES = 4;
    localparam int WRITE_STALL_CYCLES = 2;
    localparam int READ_STALL_CYCLES = 4;
    localparam int WRITE_OSC_CYCLES = 4096;
    localparam int MEM_DEPTH = 64;
    localparam int ADDR_BITS = 6;
    // nominal write time in microseconds, informative
    localparam int WRITE_TIME_MIN_US = 3100;
    localparam int WRITE_TIME_MAX_US = 6800;
    // states of the write sequencer
    typedef enum logic [1:0] {
        EB_IDLE,
        EB_WRITING
    } ebac_wstate_t;
endpackage

/* File: src/ebac_osc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two flop synchroniser with rising edge pulse for the rc oscillator
// ****************************************************************
module ebac_osc_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic oscIn,
    output logic      oscTick
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic tick_reg;
    logic tickNext;

    // edge detect looks only at the second and third stage
    always_comb begin
        tickNext = stage2_reg & ~stage3_reg;
    end

    // register the chain
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            tick_reg   <= 1'b0;
        end else begin
            stage1_reg <= oscIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            tick_reg   <= tickNext;
        end
    end

    assign oscTick = tick_reg;
endmodule
`default_nettype wire

/* File: src/ebac_top.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] a started write lasts 4096 rc oscillator cycles
// [R2] setting the write strobe stalls the cpu two cycles
// [R3] setting the read strobe stalls the cpu four cycles
// [R4] address register holds six bits, top two read zero
// [R5] reset leaves the address register untouched
// [R6] data register feeds writes and receives read bytes
// [R7] control bits seven to four read zero
// [R8] ready interrupt is a level while enabled and write strobe clear
// [R9] master write enable clears itself four cycles after setting
// [R10] write strobe starts a write only with master enable set
// [R11] master enable sets only if the same write has strobe zero
// [R12] software sets master enable then strobe within four cycles
// [R13] write strobe clears when the write time ends
// [R14] read strobe fetches the byte and clears within the instruction
// [R15] software checks write strobe is zero before a read
// [R16] writing address or data during a write aborts it
// [R17] software keeps interrupts off during the last write steps
// [R18] write strobe reads one while busy, new starts ignored
module ebac_top #(
    parameter int WRITE_OSC_CYCLES = ebac_pkg::WRITE_OSC_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ioWrite,
    input  wire logic       ioRead,
    input  wire logic [5:0] ioAddr,
    input  wire logic [7:0] ioWdata,
    input  wire logic       globalIntEnable,
    input  wire logic       rcOsc,
    output logic      [7:0] ioRdata,
    output logic            cpuStall,
    output logic            readyInterrupt
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    localparam int OSC_W = $clog2(WRITE_OSC_CYCLES + 1);

    logic [5:0]  addr_reg;
    logic [5:0]  addrNext;
    logic [7:0]  data_reg;
    logic [7:0]  dataNext;
    logic        rie_reg;
    logic        rieNext;
    logic        mwe_reg;
    logic        mweNext;
    logic [2:0]  mweCnt_reg;
    logic [2:0]  mweCntNext;
    logic        busy_reg;
    logic        busyNext;
    logic [OSC_W-1:0] oscCnt_reg;
    logic [OSC_W-1:0] oscCntNext;
    logic [5:0]  wAddr_reg;
    logic [5:0]  wAddrNext;
    logic [7:0]  wData_reg;
    logic [7:0]  wDataNext;
    logic [2:0]  stall_reg;
    logic [2:0]  stallNext;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdataNext;
    logic        irq_reg;
    logic        irqNext;
    logic        stallOut_reg;
    logic        stallOutNext;
    logic [7:0]  mem_reg [ebac_pkg::MEM_DEPTH];
    logic        oscTick;
    logic        ctrlWr;
    logic        startWrite;
    logic        startRead;
    logic        abortWrite;
    logic        writeDone;
    ebac_pkg::ebac_wstate_t wstate;

    // oscillator edge after two flop synchroniser
    ebac_osc_sync u_osc_sync (
        .clk     (clk),
        .reset   (reset),
        .oscIn   (rcOsc),
        .oscTick (oscTick)
    );

    // ****************************************************************
    // decode of control writes
    // ****************************************************************
    always_comb begin
        ctrlWr     = ioWrite && (ioAddr == ebac_pkg::CTRL_OFFSET);
        startWrite = ctrlWr && ioWdata[ebac_pkg::WRITE_STROBE_BIT]
                     && mwe_reg && !busy_reg;                 // [R10] [R18]
        startRead  = ctrlWr && ioWdata[ebac_pkg::READ_STROBE_BIT] && !busy_reg;
        abortWrite = busy_reg && ioWrite
                     && ((ioAddr == ebac_pkg::ADDR_OFFSET)
                         || (ioAddr == ebac_pkg::DATA_OFFSET)); // [R16]
        writeDone  = busy_reg && oscTick
                     && (oscCnt_reg == OSC_W'(WRITE_OSC_CYCLES - 1)); // [R1]
        wstate     = busy_reg ? ebac_pkg::EB_WRITING : ebac_pkg::EB_IDLE;
    end

    // ****************************************************************
    // address, data and control bits
    // ****************************************************************
    always_comb begin
        addrNext = addr_reg;
        dataNext = data_reg;
        rieNext  = rie_reg;
        if (ioWrite && ioAddr == ebac_pkg::ADDR_OFFSET) begin
            addrNext = ioWdata[5:0];                          // [R4]
        end
        if (ioWrite && ioAddr == ebac_pkg::DATA_OFFSET) begin
            dataNext = ioWdata;
        end
        if (startRead) begin
            dataNext = mem_reg[addr_reg];                     // [R6] [R14]
        end
        if (ctrlWr) begin
            rieNext = ioWdata[ebac_pkg::READY_INT_ENABLE_BIT];
        end
    end

    // address register has no reset on purpose
    always_ff @(posedge clk) begin
        addr_reg <= addrNext;                                 // [R5]
    end

    // data and interrupt enable
    always_ff @(posedge clk) begin
        if (reset) begin
            data_reg <= ebac_pkg::DATA_RESET;
            rie_reg  <= ebac_pkg::CTRL_RESET[0];
        end else begin
            data_reg <= dataNext;
            rie_reg  <= rieNext;
        end
    end

    // ****************************************************************
    // master write enable with timeout
    // ****************************************************************
    always_comb begin
        mweNext    = mwe_reg;
        mweCntNext = mweCnt_reg;
        if (mwe_reg) begin
            mweCntNext = mweCnt_reg + 3'h1;
            if (mweCnt_reg == 3'(ebac_pkg::MWE_TIMEOUT_CYCLES - 1)) begin
                mweNext = 1'b0;                               // [R9]
            end
        end
        if (startWrite) begin
            mweNext = 1'b0;
        end
        if (ctrlWr && ioWdata[ebac_pkg::MASTER_WRITE_ENABLE_BIT]
            && !ioWdata[ebac_pkg::WRITE_STROBE_BIT]) begin
            mweNext    = 1'b1;                                // [R11]
            mweCntNext = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mwe_reg    <= 1'b0;
            mweCnt_reg <= 3'h0;
        end else begin
            mwe_reg    <= mweNext;
            mweCnt_reg <= mweCntNext;
        end
    end

    // ****************************************************************
    // self timed write sequencer
    // ****************************************************************
    always_comb begin
        busyNext   = busy_reg;
        oscCntNext = oscCnt_reg;
        wAddrNext  = wAddr_reg;
        wDataNext  = wData_reg;
        case (wstate)
            ebac_pkg::EB_IDLE: begin
                if (startWrite) begin
                    busyNext   = 1'b1;
                    oscCntNext = '0;
                    wAddrNext  = addr_reg;
                    wDataNext  = data_reg;                    // [R6]
                end
            end
            ebac_pkg::EB_WRITING: begin
                if (abortWrite) begin
                    busyNext = 1'b0;                          // [R16]
                end else if (writeDone) begin
                    busyNext = 1'b0;                          // [R13]
                end else if (oscTick) begin
                    oscCntNext = oscCnt_reg + OSC_W'(1);      // [R1]
                end
            end
            default: begin
                busyNext = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy_reg   <= 1'b0;
            oscCnt_reg <= '0;
            wAddr_reg  <= 6'h00;
            wData_reg  <= 8'h00;
        end else begin
            busy_reg   <= busyNext;
            oscCnt_reg <= oscCntNext;
            wAddr_reg  <= wAddrNext;
            wData_reg  <= wDataNext;
        end
    end

    // ****************************************************************
    // storage array, committed when the write time ends
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < ebac_pkg::MEM_DEPTH; gi++) begin : g_mem
            always_ff @(posedge clk) begin
                if (writeDone && !abortWrite && wAddr_reg == 6'(gi)) begin
                    mem_reg[gi] <= wData_reg;                 // [R1]
                end
            end
        end
    endgenerate

    // ****************************************************************
    // cpu stall, read mux and ready interrupt
    // ****************************************************************
    always_comb begin
        stallNext = (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
        if (startWrite) begin
            stallNext = 3'(ebac_pkg::WRITE_STALL_CYCLES);     // [R2]
        end
        if (startRead) begin
            stallNext = 3'(ebac_pkg::READ_STALL_CYCLES);      // [R3]
        end
        stallOutNext = (stallNext != 3'h0);
        case (ioAddr)
            ebac_pkg::ADDR_OFFSET: rdataNext = {2'b00, addrNext};  // [R4]
            ebac_pkg::DATA_OFFSET: rdataNext = dataNext;
            ebac_pkg::CTRL_OFFSET: rdataNext = {4'h0, rieNext, mweNext,
                                                busyNext, 1'b0}; // [R7] [R14] [R18]
            default:               rdataNext = 8'h00;
        endcase
        if (!ioRead) begin
            rdataNext = rdata_reg;
        end
        irqNext = rieNext && globalIntEnable && !busyNext;    // [R8]
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stall_reg    <= 3'h0;
            stallOut_reg <= 1'b0;
            rdata_reg    <= 8'h00;
            irq_reg      <= 1'b0;
        end else begin
            stall_reg    <= stallNext;
            stallOut_reg <= stallOutNext;
            rdata_reg    <= rdataNext;
            irq_reg      <= irqNext;
        end
    end

    assign ioRdata        = rdata_reg;
    assign cpuStall       = stallOut_reg;
    assign readyInterrupt = irq_reg;
endmodule
`default_nettype wire
